/* File: core/css_map.svh */
// constants for the charge stage sequencer
// Notes on behaviour
// - pre-charge, bulk, absorption, then separate float stage
// - starting stage chosen from battery voltage
// - pre-charge regulates pre-charge current, watches voltage
// - pre-charge to bulk at bulk threshold
// - bulk to pre-charge below threshold minus hysteresis
// - bulk regulates the bulk current setpoint
// - bulk to absorption at absorption threshold
// - absorption regulates voltage, watches sourced current
// - absorption to float below float current
// - float modulates on-time at float voltage
// - float to bulk below transition threshold
// - thresholds with hysteresis judged in bulk and absorption only
// - supply out of range halts charging
// - supply recovery re-picks stage from measurements
// - battery over temperature halts charging
`ifndef CSS_MAP_SVH
`define CSS_MAP_SVH
`define CSS_VAL_W 12
`define CSS_PERIOD_W 6
`define CSS_TARGET_RST 12'h000
`define CSS_DUTY_RST 6'h00
`define CSS_DUTY_STEP 6'h01
`endif

/* File: core/css_pkg.sv */
// types for the charge stage sequencer
package css_pkg;
	// charge stages plus start-up and fault hold
	typedef enum logic [2:0] {
		STG_INIT,
		STG_PRE,
		STG_BULK,
		STG_ABS,
		STG_FLOAT,
		STG_HALT
	} css_stage_t;
endpackage

/* File: core/css_float_mod.sv */
// float stage on-time modulator
`timescale 1ns/1ns
`include "css_map.svh"
module css_float_mod
	import css_pkg::*;
#(
	parameter int PERIOD_W = `CSS_PERIOD_W
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	input wire logic en,
	// control
	input wire logic active,
	input wire logic update,
	input wire logic below,
	// drive
	output logic drive
);
	// period counter and on-time
	logic [PERIOD_W-1:0] cnt_ff;
	logic [PERIOD_W-1:0] duty_ff;
	logic [PERIOD_W-1:0] nxt_duty;
	logic drive_ff;
	wire dutyMax = &duty_ff;
	wire dutyMin = ~|duty_ff;
	wire [PERIOD_W-1:0] step = PERIOD_W'(`CSS_DUTY_STEP);

	// refuse a period that cannot modulate
	generate
		if (PERIOD_W < 2)
		begin : g_chk
			$error("css_float_mod: PERIOD_W must be at least 2");
		end
	endgenerate

	// raise on-time while battery sits below float level, lower otherwise
	assign nxt_duty = !update ? duty_ff :
		(below ? (dutyMax ? duty_ff : duty_ff + step) : (dutyMin ? duty_ff : duty_ff - step));

	// counter, duty and drive flops
	always_ff @(posedge clk)
	begin
		if (!rstn || (en && !active))
		begin
			cnt_ff <= '0;
			duty_ff <= PERIOD_W'(`CSS_DUTY_RST);
			drive_ff <= 1'b0;
		end
		else if (en)
		begin
			cnt_ff <= cnt_ff + step;
			duty_ff <= nxt_duty;
			drive_ff <= (cnt_ff < duty_ff);
		end
	end

	assign drive = drive_ff;

	a_idle_no_drive: assert property (@(posedge clk) disable iff (!rstn)
		(!active && $past(en) && !$past(active)) |-> !drive)
		else $error("float drive while inactive");
endmodule

/* File: core/css_sequencer.sv */
// charge stage sequencer top
`timescale 1ns/1ns
`include "css_map.svh"
module css_sequencer
	import css_pkg::*;
#(
	parameter int W = `CSS_VAL_W,
	parameter int PERIOD_W = `CSS_PERIOD_W
)
(
	// clock, reset, enable
	input wire logic clk,
	input wire logic rstn,
	input wire logic en,
	// measurements
	input wire logic measValid,
	input wire logic [W-1:0] battVolt,
	input wire logic [W-1:0] outCurr,
	input wire logic supplyOk,
	input wire logic [W-1:0] battTemp,
	// protection enables and limit
	input wire logic supplyChkEn,
	input wire logic tempChkEn,
	input wire logic [W-1:0] tempLimit,
	// setpoints
	input wire logic [W-1:0] preCurrSet,
	input wire logic [W-1:0] bulkCurrSet,
	input wire logic [W-1:0] bulkVoltThr,
	input wire logic [W-1:0] voltHyst,
	input wire logic [W-1:0] absVoltThr,
	input wire logic [W-1:0] floatCurrThr,
	input wire logic [W-1:0] floatVoltSet,
	input wire logic [W-1:0] floatBulkThr,
	// power stage commands
	output logic ccEn,
	output logic cvEn,
	output logic [W-1:0] currTarget,
	output logic [W-1:0] voltTarget,
	// status
	output css_stage_t stage,
	output logic halted
);
	// refuse widths the targets cannot hold
	generate
		if (W < 4 || W > 16)
		begin : g_chk
			$error("css_sequencer: W must be 4..16");
		end
	endgenerate

	// saturating subtract for hysteresis bands
	function automatic logic [W-1:0] subSat(input logic [W-1:0] a, input logic [W-1:0] b);
		subSat = (a > b) ? a - b : '0;
	endfunction

	// entry stage from the voltage picture
	function automatic css_stage_t pickStage(input logic geBulk, input logic geAbs);
		if (!geBulk)
			pickStage = STG_PRE;
		else if (!geAbs)
			pickStage = STG_BULK;
		else
			pickStage = STG_ABS;
	endfunction

	// state and registered comparisons
	css_stage_t stage_ff;
	css_stage_t nxt_stage;
	logic evalPend_ff;
	logic fault_ff;
	logic geBulk_ff;
	logic ltBulkHys_ff;
	logic geAbs_ff;
	logic ltAbsHys_ff;
	logic ltFloatCurr_ff;
	logic ltFloatBulk_ff;
	logic belowFloat_ff;
	logic ccEn_ff;
	logic cvEn_ff;
	logic [W-1:0] currTarget_ff;
	logic [W-1:0] voltTarget_ff;
	logic floatDrive;

	// fault picture
	wire supplyBad = supplyChkEn && !supplyOk;
	wire tempBad = tempChkEn && (battTemp > tempLimit);
	wire faultNow = supplyBad || tempBad;

	// compare decode, taken on each measurement update
	wire cGeBulk = battVolt >= bulkVoltThr;
	wire cLtBulkHys = battVolt < subSat(bulkVoltThr, voltHyst);
	wire cGeAbs = battVolt >= absVoltThr;
	wire cLtAbsHys = battVolt < subSat(absVoltThr, voltHyst);
	wire cLtFloatCurr = outCurr < floatCurrThr;
	wire cLtFloatBulk = battVolt < floatBulkThr;
	wire cBelowFloat = battVolt < floatVoltSet;

	// register the comparisons, evaluate one cycle later
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			evalPend_ff <= 1'b0;
			fault_ff <= 1'b0;
			geBulk_ff <= 1'b0;
			ltBulkHys_ff <= 1'b0;
			geAbs_ff <= 1'b0;
			ltAbsHys_ff <= 1'b0;
			ltFloatCurr_ff <= 1'b0;
			ltFloatBulk_ff <= 1'b0;
			belowFloat_ff <= 1'b0;
		end
		else if (en)
		begin
			evalPend_ff <= measValid;
			fault_ff <= faultNow;
			if (measValid)
			begin
				geBulk_ff <= cGeBulk;
				ltBulkHys_ff <= cLtBulkHys;
				geAbs_ff <= cGeAbs;
				ltAbsHys_ff <= cLtAbsHys;
				ltFloatCurr_ff <= cLtFloatCurr;
				ltFloatBulk_ff <= cLtFloatBulk;
				belowFloat_ff <= cBelowFloat;
			end
		end
	end

	// stage transitions, at most one step per update
	always_comb
	begin
		nxt_stage = stage_ff;
		if (fault_ff && stage_ff != STG_HALT)
			nxt_stage = STG_HALT;
		else if (evalPend_ff)
		begin
			unique case (stage_ff)
				STG_INIT: nxt_stage = pickStage(geBulk_ff, geAbs_ff);
				STG_PRE: if (geBulk_ff) nxt_stage = STG_BULK;
				STG_BULK:
				begin
					if (ltBulkHys_ff)
						nxt_stage = STG_PRE;
					else if (geAbs_ff)
						nxt_stage = STG_ABS;
				end
				STG_ABS:
				begin
					if (ltAbsHys_ff)
						nxt_stage = STG_BULK;
					else if (ltFloatCurr_ff)
						nxt_stage = STG_FLOAT;
				end
				STG_FLOAT: if (ltFloatBulk_ff) nxt_stage = STG_BULK;
				STG_HALT: if (!fault_ff) nxt_stage = pickStage(geBulk_ff, geAbs_ff);
			endcase
		end
	end

	// command decode per stage
	wire inPre = stage_ff == STG_PRE;
	wire inBulk = stage_ff == STG_BULK;
	wire inAbs = stage_ff == STG_ABS;
	wire inFloat = stage_ff == STG_FLOAT;
	wire nxtCc = inPre || inBulk;
	wire nxtCv = inAbs || (inFloat && floatDrive);
	wire [W-1:0] nxtCurr = inPre ? preCurrSet : (inBulk ? bulkCurrSet : '0);
	wire [W-1:0] nxtVolt = inAbs ? absVoltThr : (inFloat ? floatVoltSet : '0);

	// stage and command flops
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			stage_ff <= STG_INIT;
			ccEn_ff <= 1'b0;
			cvEn_ff <= 1'b0;
			currTarget_ff <= W'(`CSS_TARGET_RST);
			voltTarget_ff <= W'(`CSS_TARGET_RST);
		end
		else if (en)
		begin
			stage_ff <= nxt_stage;
			ccEn_ff <= nxtCc;
			cvEn_ff <= nxtCv;
			currTarget_ff <= nxtCurr;
			voltTarget_ff <= nxtVolt;
		end
	end

	// float on-time modulation
	css_float_mod #(
		.PERIOD_W(PERIOD_W)
	) u_float (
		.clk(clk),
		.rstn(rstn),
		.en(en),
		.active(inFloat),
		.update(evalPend_ff),
		.below(belowFloat_ff),
		.drive(floatDrive)
	);

	assign ccEn = ccEn_ff;
	assign cvEn = cvEn_ff;
	assign currTarget = currTarget_ff;
	assign voltTarget = voltTarget_ff;
	assign stage = stage_ff;
	assign halted = stage_ff == STG_HALT;

	// checks on stage flow and commands
	a_halt_no_drive: assert property (@(posedge clk) disable iff (!rstn)
		(halted && $past(en) && $past(halted)) |-> (!ccEn && !cvEn))
		else $error("drive while halted");
	a_pre_current: assert property (@(posedge clk) disable iff (!rstn)
		(en && inPre) |=> (ccEn && !cvEn && currTarget == $past(preCurrSet)))
		else $error("pre-charge current wrong");
	a_bulk_current: assert property (@(posedge clk) disable iff (!rstn)
		(en && inBulk) |=> (ccEn && currTarget == $past(bulkCurrSet)))
		else $error("bulk current wrong");
	a_abs_voltage: assert property (@(posedge clk) disable iff (!rstn)
		(en && inAbs) |=> (cvEn && !ccEn && voltTarget == $past(absVoltThr)))
		else $error("absorption not in voltage mode");
	a_pre_to_bulk: assert property (@(posedge clk) disable iff (!rstn)
		(en && inPre && evalPend_ff && !fault_ff && geBulk_ff) |=> stage == STG_BULK)
		else $error("missed pre-charge to bulk");
	a_bulk_to_pre: assert property (@(posedge clk) disable iff (!rstn)
		(en && inBulk && evalPend_ff && !fault_ff && ltBulkHys_ff) |=> stage == STG_PRE)
		else $error("missed bulk to pre-charge");
	a_bulk_to_abs: assert property (@(posedge clk) disable iff (!rstn)
		(en && inBulk && evalPend_ff && !fault_ff && !ltBulkHys_ff && geAbs_ff)
		|=> stage == STG_ABS)
		else $error("missed bulk to absorption");
	a_abs_to_float: assert property (@(posedge clk) disable iff (!rstn)
		(en && inAbs && evalPend_ff && !fault_ff && !ltAbsHys_ff && ltFloatCurr_ff)
		|=> stage == STG_FLOAT)
		else $error("missed absorption to float");
	a_abs_to_bulk: assert property (@(posedge clk) disable iff (!rstn)
		(en && inAbs && evalPend_ff && !fault_ff && ltAbsHys_ff) |=> stage == STG_BULK)
		else $error("missed absorption to bulk");
	a_float_to_bulk: assert property (@(posedge clk) disable iff (!rstn)
		(en && inFloat && evalPend_ff && !fault_ff && ltFloatBulk_ff) |=> stage == STG_BULK)
		else $error("missed float to bulk");
	a_fault_halts: assert property (@(posedge clk) disable iff (!rstn)
		(en && faultNow) ##1 en |=> halted)
		else $error("fault did not halt");
	a_step_on_update: assert property (@(posedge clk) disable iff (!rstn)
		(stage != $past(stage)) |-> ($past(evalPend_ff) || ($past(fault_ff) && halted)))
		else $error("stage moved without update");

	c_full_charge: cover property (@(posedge clk) disable iff (!rstn)
		inAbs ##1 inFloat);
	c_fault_resume: cover property (@(posedge clk) disable iff (!rstn)
		halted ##1 !halted);
	c_bulk_fallback: cover property (@(posedge clk) disable iff (!rstn)
		inBulk ##1 inPre);
endmodule

/* File: tb/css_batt_model.sv */
// battery and power stage model facing the sequencer
`timescale 1ns/1ns
module css_batt_model #(
	parameter int W = 12
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// commands from the sequencer
	input wire logic ccEn,
	input wire logic cvEn,
	input wire logic [W-1:0] currTarget,
	// battery state chosen by the bench
	input wire logic [W-1:0] setVolt,
	input wire logic [W-1:0] setCurr,
	// measurements
	output logic [W-1:0] battVolt,
	output logic [W-1:0] outCurr,
	output logic measValid
);
	logic [2:0] tick_ff; // update spacing
	// free counter, one update every eight cycles
	always_ff @(posedge clk)
	begin
		if (!rstn)
			tick_ff <= 3'h0;
		else
			tick_ff <= tick_ff + 3'h1;
	end
	assign measValid = (tick_ff == 3'h7);
	assign battVolt = setVolt; // terminal voltage
	// cc sources its target, cv sources what the battery takes
	assign outCurr = cvEn ? setCurr : (ccEn ? currTarget : '0);
endmodule

/* File: tb/test_charge_stage_sequencer.sv */
// self-checking bench for the charge stage sequencer
`timescale 1ns/1ns
module test_charge_stage_sequencer;
	import css_pkg::*;
	localparam int W = 12;
	localparam logic [W-1:0] PRE_I = 12'h020, BULK_I = 12'h100, BULK_V = 12'h400;
	localparam logic [W-1:0] HYST = 12'h080, ABS_V = 12'h600, FLT_I = 12'h050;
	localparam logic [W-1:0] FLT_V = 12'h580, FB_V = 12'h500, T_LIM = 12'h300;
	logic clk, rstn, en, supplyOk, supplyChkEn, tempChkEn, measValid;
	logic ccEn, cvEn, halted;
	logic [W-1:0] battTemp, setVolt, setCurr, battVolt, outCurr, currTarget, voltTarget;
	css_stage_t stage;
	int mismatches, samples_checked;
	// device under test, short float period
	css_sequencer #(.W(W), .PERIOD_W(3)) css_sequencer_inst (.clk(clk), .rstn(rstn),
		.en(en), .measValid(measValid), .battVolt(battVolt), .outCurr(outCurr),
		.supplyOk(supplyOk), .battTemp(battTemp), .supplyChkEn(supplyChkEn),
		.tempChkEn(tempChkEn), .tempLimit(T_LIM), .preCurrSet(PRE_I),
		.bulkCurrSet(BULK_I), .bulkVoltThr(BULK_V), .voltHyst(HYST), .absVoltThr(ABS_V),
		.floatCurrThr(FLT_I), .floatVoltSet(FLT_V), .floatBulkThr(FB_V), .ccEn(ccEn),
		.cvEn(cvEn), .currTarget(currTarget), .voltTarget(voltTarget), .stage(stage),
		.halted(halted));
	// battery on the far side
	css_batt_model #(.W(W)) css_batt_model_inst (.clk(clk), .rstn(rstn), .ccEn(ccEn),
		.cvEn(cvEn), .currTarget(currTarget), .setVolt(setVolt), .setCurr(setCurr),
		.battVolt(battVolt), .outCurr(outCurr), .measValid(measValid));
	// clock, 4 ns period
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// n edges, then settle past the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// compare and count
	task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// bounded wait for a stage, then let commands follow
	task automatic waitStg(input css_stage_t exp);
		int n;
		n = 0;
		while (stage !== exp && n < 64)
		begin
			cyc(1);
			n++;
		end
		cyc(2);
		check(W'(stage), W'(exp));
	endtask
	// stage must hold over several updates
	task automatic holdStg(input css_stage_t exp);
		cyc(24);
		check(W'(stage), W'(exp));
	endtask
	// power stage command set
	task automatic cmds(input logic cc, input logic cv, input logic [W-1:0] ct,
		input logic [W-1:0] vt);
		check(W'(ccEn), W'(cc));
		check(W'(cvEn), W'(cv));
		check(currTarget, ct);
		check(voltTarget, vt);
	endtask
	// start low, bulk boundary, hysteresis both ways
	task automatic tPreBulk();
		waitStg(STG_PRE);
		cmds(1'b1, 1'b0, PRE_I, '0);
		setVolt = BULK_V - 12'h001;
		holdStg(STG_PRE);
		setVolt = BULK_V;
		waitStg(STG_BULK);
		cmds(1'b1, 1'b0, BULK_I, '0);
		setVolt = BULK_V - HYST;
		holdStg(STG_BULK);
		setVolt = BULK_V - HYST - 12'h001;
		waitStg(STG_PRE);
	endtask
	// jump far past both thresholds, one step per update
	task automatic tStep();
		int n;
		n = 0;
		setVolt = 12'h700;
		while (stage === STG_PRE && n < 64)
		begin
			cyc(1);
			n++;
		end
		check(W'(stage), W'(STG_BULK));
		waitStg(STG_ABS);
		cmds(1'b0, 1'b1, '0, ABS_V);
		// absorption falls back to bulk only past the hysteresis band
		setVolt = ABS_V - HYST;
		holdStg(STG_ABS);
		setVolt = ABS_V - HYST - 12'h001;
		waitStg(STG_BULK);
		cmds(1'b1, 1'b0, BULK_I, '0);
		setVolt = 12'h700;
		waitStg(STG_ABS);
	endtask
	// full battery, float modulation, load drop
	task automatic tFloat();
		int hi;
		hi = 0;
		setCurr = FLT_I;
		holdStg(STG_ABS);
		setCurr = FLT_I - 12'h001;
		waitStg(STG_FLOAT);
		check(voltTarget, FLT_V);
		setVolt = 12'h560;
		repeat (64)
		begin
			cyc(1);
			hi += int'(cvEn === 1'b1);
		end
		check(W'(hi > 0 && hi < 64), W'(1'b1));
		check(W'(ccEn), '0);
		// duty pinned at its top: on for all but one cycle of eight
		hi = 0;
		repeat (8)
		begin
			cyc(1);
			hi += int'(cvEn === 1'b1);
		end
		check(W'(hi), W'(7));
		// battery above float level: on-time walks back down to none
		setVolt = 12'h5C0;
		cyc(80);
		hi = 0;
		repeat (16)
		begin
			cyc(1);
			hi += int'(cvEn === 1'b1);
		end
		check(W'(hi), W'(0));
		check(voltTarget, FLT_V);
		setVolt = FB_V;
		holdStg(STG_FLOAT);
		setVolt = FB_V - 12'h001;
		waitStg(STG_BULK);
		cmds(1'b1, 1'b0, BULK_I, '0);
	endtask
	// supply and temperature faults, then recovery
	task automatic tFault();
		supplyOk = 1'b0;
		waitStg(STG_HALT);
		check(W'(halted), W'(1'b1));
		cmds(1'b0, 1'b0, '0, '0);
		supplyOk = 1'b1;
		setVolt = 12'h300;
		waitStg(STG_PRE);
		battTemp = T_LIM;
		holdStg(STG_PRE);
		battTemp = T_LIM + 12'h001;
		waitStg(STG_HALT);
		cmds(1'b0, 1'b0, '0, '0);
		setVolt = 12'h4F0;
		battTemp = 12'h100;
		waitStg(STG_BULK);
	endtask
	// checks disabled, then clock enable low, then release
	task automatic tGate();
		supplyChkEn = 1'b0;
		tempChkEn = 1'b0;
		supplyOk = 1'b0;
		battTemp = T_LIM + 12'h001;
		holdStg(STG_BULK);
		check(W'(halted), '0);
		supplyOk = 1'b1;
		battTemp = 12'h100;
		supplyChkEn = 1'b1;
		tempChkEn = 1'b1;
		en = 1'b0;
		setVolt = 12'h300;
		holdStg(STG_BULK);
		cmds(1'b1, 1'b0, BULK_I, '0);
		en = 1'b1;
		waitStg(STG_PRE);
		cmds(1'b1, 1'b0, PRE_I, '0);
	endtask
	// reset in mid-run, battery already high enough for absorption
	task automatic tReset();
		rstn = 1'b0;
		setVolt = 12'h700;
		cyc(2);
		check(W'(stage), W'(STG_INIT));
		cmds(1'b0, 1'b0, '0, '0);
		rstn = 1'b1;
		waitStg(STG_ABS);
		cmds(1'b0, 1'b1, '0, ABS_V);
	endtask
	// counts and verdict
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// main sequence
	initial
	begin
		mismatches = 0;
		samples_checked = 0;
		rstn = 1'b0;
		en = 1'b1;
		supplyOk = 1'b1;
		supplyChkEn = 1'b1;
		tempChkEn = 1'b1;
		battTemp = 12'h100;
		setVolt = 12'h300;
		setCurr = 12'h200;
		cyc(20);
		check(W'(stage), W'(STG_INIT));
		cmds(1'b0, 1'b0, '0, '0);
		rstn = 1'b1;
		tPreBulk();
		tStep();
		tFloat();
		tFault();
		tGate();
		tReset();
		end_sim();
	end
	// hang guard
	initial
	begin
		#40000;
		mismatches++;
		end_sim();
	end
endmodule
